// File: shared/bswsc_pkg.sv
package bswsc_pkg;
  // register map: the byte address is four times the word index, and the
  // 8-bit window only decodes the low six bits of the index, so aliases above them are not seen
  localparam logic [15:0] BSWSC_CTRL_INDEX = 16'hffc2;
  localparam logic [7:0] BSWSC_CTRL_ADDR = {BSWSC_CTRL_INDEX[5:0], 2'h0};
  localparam logic [7:0] BSWSC_STAT_ADDR = 8'h0c;
  localparam logic [7:0] BSWSC_CTRL_RESET = 8'h08;
  // field positions of the wait and clock control register
  localparam int BSWSC_EMUL_RAM_SELECT = 7;
  localparam int BSWSC_EMUL_AREA_PICK = 6;
  localparam int BSWSC_PERIPH_CLOCK_HALVE = 5;
  localparam int BSWSC_FLASH_REGS_VISIBLE = 4;
  localparam int BSWSC_WAIT_MODE_HI = 3;
  localparam int BSWSC_WAIT_MODE_LO = 2;
  localparam int BSWSC_WAIT_COUNT_HI = 1;
  localparam int BSWSC_WAIT_COUNT_LO = 0;
  // wait mode encodings
  localparam logic [1:0] BSWSC_MODE_PROG = 2'h0;
  localparam logic [1:0] BSWSC_MODE_NONE = 2'h1;
  localparam logic [1:0] BSWSC_MODE_PIN = 2'h2;
  localparam logic [1:0] BSWSC_MODE_AUTO = 2'h3;
  // axi responses
  localparam logic [1:0] BSWSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] BSWSC_RESP_SLVERR = 2'h2;
  // bus cycle states
  typedef enum logic [1:0] {BSWSC_IDLE, BSWSC_SECOND, BSWSC_DELAY, BSWSC_FINAL} bswsc_state_type;
endpackage

// File: hw/bswsc_seq.sv
`timescale 1ns/1ps
// ----------------------------------------
// bus cycle stretcher
// ----------------------------------------
// one bus access: start, second state, then wait states, then a final state ends it with done.
// the wait pin is sampled on the clock edge standing in for the mid-state fall.
module bswsc_seq
  import bswsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] wait_mode,
  input wire logic [1:0] wait_count,
  input wire logic bus_start,
  input wire logic bus_external,
  input wire logic wait_req_n,
  output logic bus_busy,
  output logic bus_done,
  output logic [7:0] waits_inserted
);
  bswsc_state_type state_ff, nxt_state;
  logic [1:0] left_ff, nxt_left;
  logic [7:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;
  logic ext_ff, nxt_ext;

  wire pin_low = ~wait_req_n;
  wire mode_prog = (wait_mode == BSWSC_MODE_PROG);
  wire mode_pin = (wait_mode == BSWSC_MODE_PIN);
  wire mode_auto = (wait_mode == BSWSC_MODE_AUTO);
  wire has_count = (wait_count != 2'h0);
  // internal targets never stretch; no-wait mode never stretches
  wire fixed_waits = ext_ff && (mode_prog || mode_pin) && has_count;
  wire auto_waits = ext_ff && mode_auto && has_count && pin_low;
  wire pin_extra = ext_ff && mode_pin && pin_low;

  // next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_left = left_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    nxt_ext = ext_ff;
    case (state_ff)
      BSWSC_IDLE: begin
        if (bus_start) begin
          nxt_state = BSWSC_SECOND;
          nxt_ext = bus_external;
          nxt_cnt = 8'h00;
        end
      end
      BSWSC_SECOND: begin
        nxt_left = wait_count;
        if (fixed_waits || auto_waits) begin
          nxt_state = BSWSC_DELAY;
        end else if (pin_extra) begin
          // count of zero: pin checked in the second state itself
          nxt_state = BSWSC_DELAY;
          nxt_left = 2'h1;
        end else begin
          nxt_state = BSWSC_FINAL;
        end
      end
      BSWSC_DELAY: begin
        nxt_cnt = cnt_ff + 8'h01;
        if (left_ff > 2'h1) begin
          nxt_left = left_ff - 2'h1;
        end else if (pin_extra) begin
          nxt_left = 2'h1;
        end else begin
          nxt_state = BSWSC_FINAL;
        end
      end
      BSWSC_FINAL: begin
        nxt_state = BSWSC_IDLE;
        nxt_done = 1'b1;
      end
      default: nxt_state = BSWSC_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= BSWSC_IDLE;
      left_ff <= 2'h0;
      cnt_ff <= 8'h00;
      done_ff <= 1'b0;
      ext_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      left_ff <= nxt_left;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
      ext_ff <= nxt_ext;
    end
  end

  assign bus_busy = (state_ff != BSWSC_IDLE);
  assign bus_done = done_ff;
  assign waits_inserted = cnt_ff;
endmodule // bswsc_seq

// File: hw/bswsc_top.sv
`timescale 1ns/1ps
// Functional notes
// - 8-bit read-write control register resets to 08, also on hardware standby
// - software standby leaves the control register untouched
// - bits 3:2 mode: 00 programmable, 01 none, 10 pin, 11 pin auto
// - bits 1:0 give zero to three wait states, default zero
// - programmable mode inserts exactly the count into external accesses
// - pin mode: count waits, then pin low in last wait adds one
// - pin mode keeps adding waits while pin low; far end releases it
// - auto mode samples pin in second state; inserts count only if low
// - auto mode never goes beyond the count
// - bit 5 halves the supporting-module clock when set
// - bit 4 maps flash control registers; plain storage otherwise, resets 0
// - bits 7:6 are storage picking the emulation ram area, reset 0
// - system clock equals oscillator input clock, no division
// - register sits at index ffc2 of the device register space
module bswsc_top
  import bswsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_start,
  input wire logic bus_external,
  input wire logic wait_req_n,
  output logic bus_busy,
  output logic bus_done,
  output logic sys_clk_en,
  output logic periph_clk_en,
  output logic flash_regs_visible,
  output logic emul_ram_select,
  output logic emul_area_pick
);
  // ----------------------------------------
  // register write path
  // ----------------------------------------
  logic [7:0] ctrl_ff;
  logic aw_ff, w_ff, bvalid_ff, bad_w_ff;
  logic [7:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wstrb0_ff;
  logic arvalid_seen;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic half_ff;
  logic [7:0] waits_cnt;

  // address and data are captured independently, in either order
  wire aw_take = s_axi_awvalid && !aw_ff && !bvalid_ff;
  wire w_take = s_axi_wvalid && !w_ff && !bvalid_ff;
  wire both_in = aw_ff && w_ff;
  wire ctrl_hit = (awaddr_ff == BSWSC_CTRL_ADDR);
  wire ctrl_wr = both_in && ctrl_hit && wstrb0_ff;
  wire [7:0] nxt_ctrl = ctrl_wr ? wbyte_ff : ctrl_ff;

  // accept channels and raise the response once both have arrived
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bad_w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wbyte_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_ff <= 1'b1;
        wbyte_ff <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (both_in) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bad_w_ff <= !ctrl_hit;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // control register; standby entry only restores it for hardware standby
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      ctrl_ff <= BSWSC_CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign s_axi_awready = aw_take;
  assign s_axi_wready = w_take;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bad_w_ff ? BSWSC_RESP_SLVERR : BSWSC_RESP_OKAY;

  // ----------------------------------------
  // register read path
  // ----------------------------------------
  wire ar_take = s_axi_arvalid && !rvalid_ff;
  wire rd_ctrl = (s_axi_araddr == BSWSC_CTRL_ADDR);
  wire rd_stat = (s_axi_araddr == BSWSC_STAT_ADDR);
  // status: waits added in the latest access and the busy flag
  wire [31:0] stat_word = {23'h000000, bus_busy, waits_cnt};
  wire [31:0] rd_word = rd_ctrl ? {24'h000000, ctrl_ff} : (rd_stat ? stat_word : 32'h00000000);
  wire [1:0] rd_resp = (rd_ctrl || rd_stat) ? BSWSC_RESP_OKAY : BSWSC_RESP_SLVERR;
  assign arvalid_seen = ar_take;

  // read data held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= BSWSC_RESP_OKAY;
    end else if (arvalid_seen) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_arready = ar_take;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ----------------------------------------
  // bus cycle stretcher
  // ----------------------------------------
  bswsc_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .wait_mode(ctrl_ff[BSWSC_WAIT_MODE_HI:BSWSC_WAIT_MODE_LO]),
    .wait_count(ctrl_ff[BSWSC_WAIT_COUNT_HI:BSWSC_WAIT_COUNT_LO]),
    .bus_start(bus_start),
    .bus_external(bus_external),
    .wait_req_n(wait_req_n),
    .bus_busy(bus_busy),
    .bus_done(bus_done),
    .waits_inserted(waits_cnt)
  );

  // ----------------------------------------
  // clock enables
  // ----------------------------------------
  // enables rather than gated clocks, so the whole block stays on aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= !half_ff;
    end
  end

  assign sys_clk_en = 1'b1;
  assign periph_clk_en = ctrl_ff[BSWSC_PERIPH_CLOCK_HALVE] ? half_ff : 1'b1;
  assign flash_regs_visible = ctrl_ff[BSWSC_FLASH_REGS_VISIBLE];
  assign emul_ram_select = ctrl_ff[BSWSC_EMUL_RAM_SELECT];
  assign emul_area_pick = ctrl_ff[BSWSC_EMUL_AREA_PICK];
endmodule // bswsc_top

// File: sim/bswsc_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the bus stretch controller
// ----------------------------------------
module bswsc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hw_standby,
  input wire logic s_axi_bvalid,
  input wire logic bus_start,
  input wire logic bus_external,
  input wire logic bus_busy,
  input wire logic bus_done,
  input wire logic sys_clk_en,
  input wire logic periph_clk_en,
  input wire logic flash_regs_visible,
  input wire logic emul_ram_select,
  input wire logic emul_area_pick
);
  logic go;
  // a start only counts in idle outside done; the sequencer still takes a start during done
  assign go = bus_start && !bus_busy && !bus_done;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_min_length: assert property (go |=> (bus_busy && !bus_done)[*2])
    else $error("access ended too early");
  a_done_ends_busy: assert property (bus_done |-> !bus_busy && $past(bus_busy))
    else $error("done without a busy access");
  a_done_pulse: assert property (bus_done |=> !bus_done)
    else $error("done longer than one cycle");
  a_internal_fast: assert property (go && !bus_external |-> ##3 bus_done)
    else $error("internal access was stretched");
  a_periph_rate: assert property (!periph_clk_en |=> periph_clk_en)
    else $error("supporting clock slower than half rate");
  a_sys_clock: assert property (sys_clk_en)
    else $error("system clock gated");
  a_reset_value: assert property ($rose(aresetn) |-> periph_clk_en && !flash_regs_visible
    && !emul_ram_select && !emul_area_pick)
    else $error("control bits wrong after reset");
  a_hw_standby: assert property (hw_standby |=> !flash_regs_visible && !emul_area_pick)
    else $error("standby did not restore control");
  a_store_on_write: assert property ($changed(emul_ram_select) |-> $rose(s_axi_bvalid)
    || $past(hw_standby))
    else $error("control changed without a write");
endmodule // bswsc_chk

bind bswsc_top bswsc_chk bswsc_chk_i (.aclk, .aresetn, .hw_standby, .s_axi_bvalid, .bus_start,
  .bus_external, .bus_busy, .bus_done, .sys_clk_en, .periph_clk_en, .flash_regs_visible,
  .emul_ram_select, .emul_area_pick);

// File: sim/bswsc_mem.sv
`timescale 1ns/1ps
// ----------------------------------------
// slow external device on the wait pin
// ----------------------------------------
module bswsc_mem (
  input wire logic aclk,
  input wire logic bus_start,
  input wire logic bus_external,
  input wire logic [3:0] hold_len,
  output logic wait_req_n
);
  logic [3:0] cnt_ff = 4'h0;
  // holds wait low for hold_len cycles; internal accesses never see a request
  always_ff @(posedge aclk) begin
    if (bus_start) cnt_ff <= bus_external ? hold_len : 4'h0;
    else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
  end
  // released pin is pulled high, so the access can end
  assign wait_req_n = (cnt_ff == 4'h0);
endmodule // bswsc_mem

// File: sim/tb_bus_wait_state_control.sv
`timescale 1ns/1ps
module tb_bus_wait_state_control
  import bswsc_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, hw_standby = 1'b0, sw_standby = 1'b0;
  logic bus_start = 1'b0, bus_external = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, model = 8'h08;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0, hold_len = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wait_req_n;
  logic bus_busy, bus_done, sys_clk_en, periph_clk_en, flash_regs_visible;
  logic emul_ram_select, emul_area_pick;
  int failures = 0, tests_run = 0, n, last_w = 0;
  int unsigned seed = 5132;
  bswsc_top bswsc_top_i (.aclk, .aresetn, .hw_standby, .sw_standby, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_start, .bus_external,
    .wait_req_n, .bus_busy, .bus_done, .sys_clk_en, .periph_clk_en, .flash_regs_visible,
    .emul_ram_select, .emul_area_pick);
  bswsc_mem bswsc_mem_i (.aclk, .bus_start, .bus_external, .hold_len, .wait_req_n);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // write: each channel dropped when taken; the model stores byte 0 of the control word
  task automatic wr(logic [7:0] a, logic [7:0] d, logic [3:0] s);
    logic [1:0] er;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    er = (a == BSWSC_CTRL_ADDR) ? BSWSC_RESP_OKAY : BSWSC_RESP_SLVERR;
    chk("bresp", er, s_axi_bresp);
    if (a == BSWSC_CTRL_ADDR && s[0]) model = d;
    @(posedge aclk);
  endtask
  task automatic rd(logic [7:0] a);
    logic [31:0] e;
    logic hit;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    // status holds the waits of the latest access; the bus is idle when it is read
    hit = (a == BSWSC_CTRL_ADDR) || (a == BSWSC_STAT_ADDR);
    if (a == BSWSC_CTRL_ADDR) e = {24'h0, model};
    else if (a == BSWSC_STAT_ADDR) e = {24'h0, 8'(last_w)};
    else e = 32'h0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", hit ? BSWSC_RESP_OKAY : BSWSC_RESP_SLVERR, s_axi_rresp);
    @(posedge aclk);
  endtask
  // one access; cycles from start to done are second state + waits + final state + 1
  task automatic acc(logic e, logic [3:0] l, int md, int c);
    int w;
    w = (md == 3) ? ((l > 0) ? c : 0) : (md == 2 && l > c) ? int'(l) : c;
    if (!e || md == 1) w = 0;
    hold_len <= l;
    bus_external <= e;
    bus_start <= 1'b1;
    @(posedge aclk);
    bus_start <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!bus_done && n < 40);
    last_w = w;
    chk("cycles", w + 3, n);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  // free-running 200 MHz clock
  initial forever #2.5 aclk = ~aclk;
  // hang guard: the sequence needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    stop_test();
  end
  initial begin
    logic p;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(BSWSC_CTRL_ADDR);
    repeat (8) begin
      wr(BSWSC_CTRL_ADDR, 8'(rnd()), 4'(rnd()));
      rd(BSWSC_CTRL_ADDR);
      chk("ram_sel", model[7], emul_ram_select);
      chk("ram_area", model[6], emul_area_pick);
      chk("flash_vis", model[4], flash_regs_visible);
      p = periph_clk_en;
      @(posedge aclk);
      chk("pclk", model[5] ? !p : 1'b1, periph_clk_en);
    end
    wr(8'h10, 8'hff, 4'hf);
    rd(8'h10);
    sw_standby <= 1'b1;
    repeat (4) @(posedge aclk);
    sw_standby <= 1'b0;
    rd(BSWSC_CTRL_ADDR);
    hw_standby <= 1'b1;
    @(posedge aclk);
    hw_standby <= 1'b0;
    model = BSWSC_CTRL_RESET;
    rd(BSWSC_CTRL_ADDR);
    for (int md = 0; md < 4; md++) begin
      for (int c = 0; c < 4; c++) begin
        repeat (2) begin
          wr(BSWSC_CTRL_ADDR, 8'(md * 4 + c), 4'h1);
          acc(rnd() % 4 != 0, 4'(rnd() % 7), md, c);
          rd(BSWSC_STAT_ADDR);
        end
      end
    end
    stop_test();
  end
endmodule // tb_bus_wait_state_control
